// ==== hscp_pkg.sv ====
// Shared constants, types and helpers for the hub strap capture block
package hscp_pkg;

  // ****************************************
  // Sizes and constants
  // ****************************************
  localparam int NumPorts = 7;
  localparam int SyncStages = 2;
  // Select code {hi, lo} that picks the strap based default configuration
  localparam logic [1:0] CfgSelStrap = 2'h2;
  localparam logic ValidAtReset = 1'h0;
  localparam logic [7:1] PortsOff = 7'h00;
  localparam logic [7:1] OverAtReset = 7'h00;

  // ****************************************
  // Types
  // ****************************************
  // Pin levels that enter through the synchroniser
  typedef struct packed {
    logic cfgSelHi;
    logic cfgSelLo;
    logic ind4;
    logic ind2;
    logic ind1;
    logic supplyLevel;
    logic [7:1] overN;
  } hscp_pins_s;

  // Configuration in force after reset release
  typedef struct packed {
    logic useStrap;
    logic indicatorEnable;
    logic multiTranslators;
    logic ganged;
    logic supplyLevel;
  } hscp_cfg_s;

  // ****************************************
  // Helpers
  // ****************************************
  // Maps a set of "on" requests to pin levels for a given active level
  function automatic logic [7:1] hscp_level(input logic [7:1] on, input logic activeHigh);
    return activeHigh ? on : ~on;
  endfunction

  // Single indicator pin level for a given active level
  function automatic logic hscp_led(input logic on, input logic activeHigh);
    return activeHigh ? on : ~on;
  endfunction

endpackage

// ==== hscp_sync.sv ====
// Two stage synchroniser for a vector of pin levels
`timescale 1ns/1ps
module hscp_sync #(
  parameter int Width = 1
) (
  // Clock
  input wire logic clk,
  // Pin side
  input wire logic [Width-1:0] d,
  // Core side
  output logic [Width-1:0] q
);
  logic [Width-1:0] meta;

  // No reset: straps must keep flowing while reset is held
  always_ff @(posedge clk) begin
    meta <= d;
    q <= meta;
  end
endmodule

// ==== hscp_strap_capture.sv ====
// Reset time strap capture, indicator and port power polarity for the hub
`timescale 1ns/1ps

module hscp_strap_capture
  import hscp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration select pins
  input wire logic configMethodSelectHi,
  input wire logic configMethodSelectLo,
  // Loaded configuration, used when straps are not selected
  input wire logic cfgIndicatorEnable,
  input wire logic cfgMultiTranslators,
  input wire logic cfgGanged,
  // Indicator requests from the hub core
  input wire logic [4:1] amberReq,
  // Port 4 indicator pin
  input wire logic port4AmberIndicatorIn,
  output logic port4AmberIndicatorOut,
  output logic port4AmberIndicatorOe,
  // Port 3 indicator pin
  output logic port3AmberIndicatorOut,
  output logic port3AmberIndicatorOe,
  // Port 2 indicator pin
  input wire logic port2AmberIndicatorIn,
  output logic port2AmberIndicatorOut,
  output logic port2AmberIndicatorOe,
  // Port 1 indicator pin
  input wire logic port1AmberIndicatorIn,
  output logic port1AmberIndicatorOut,
  output logic port1AmberIndicatorOe,
  // Port power
  input wire logic supplySwitchLevelStrap,
  input wire logic [7:1] portPowerReq,
  output logic [7:1] downstreamSupplyEnable,
  // Over-current sensing
  input wire logic [7:1] overcurrentSenseN,
  output logic [7:1] overcurrent,
  // Configuration in force
  output hscp_cfg_s activeCfg,
  output logic strapsValid
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  hscp_pins_s pinRaw;
  hscp_pins_s pinSync;

  assign pinRaw = '{
    cfgSelHi: configMethodSelectHi,
    cfgSelLo: configMethodSelectLo,
    ind4: port4AmberIndicatorIn,
    ind2: port2AmberIndicatorIn,
    ind1: port1AmberIndicatorIn,
    supplyLevel: supplySwitchLevelStrap,
    overN: overcurrentSenseN
  };

  hscp_sync #(
    .Width($bits(hscp_pins_s))
  ) u_sync (
    .clk(clk),
    .d(pinRaw),
    .q(pinSync)
  );

  // ****************************************
  // Strap capture
  // ****************************************
  hscp_pins_s cap;
  logic capStrapMode;

  // Follows the pins while reset is held, freezes at release
  always_ff @(posedge clk) begin
    if (rst) begin
      cap <= pinSync;
    end
  end

  assign capStrapMode = ({cap.cfgSelHi, cap.cfgSelLo} == CfgSelStrap);

  always_ff @(posedge clk) begin
    if (rst) begin
      strapsValid <= ValidAtReset;
    end else begin
      strapsValid <= 1'h1;
    end
  end

  // Effective configuration, straps or loaded settings
  hscp_cfg_s next_activeCfg;

  always_comb begin
    next_activeCfg.useStrap = capStrapMode;
    next_activeCfg.supplyLevel = cap.supplyLevel;
    if (capStrapMode) begin
      next_activeCfg.indicatorEnable = cap.ind4;
      next_activeCfg.multiTranslators = cap.ind2;
      next_activeCfg.ganged = cap.ind1;
    end else begin
      next_activeCfg.indicatorEnable = cfgIndicatorEnable;
      next_activeCfg.multiTranslators = cfgMultiTranslators;
      next_activeCfg.ganged = cfgGanged;
    end
  end

  always_ff @(posedge clk) begin
    activeCfg <= next_activeCfg;
  end

  // ****************************************
  // Amber indicators
  // ****************************************
  // Pins 4, 2, 1 stay released during reset so the straps can be read
  always_ff @(posedge clk) begin
    if (rst) begin
      port4AmberIndicatorOe <= 1'h0;
      port2AmberIndicatorOe <= 1'h0;
      port1AmberIndicatorOe <= 1'h0;
      port4AmberIndicatorOut <= 1'h1;
      port2AmberIndicatorOut <= 1'h1;
      port1AmberIndicatorOut <= 1'h1;
    end else if (capStrapMode) begin
      port4AmberIndicatorOe <= 1'h1;
      port4AmberIndicatorOut <= cap.ind4 ? ~amberReq[4] : 1'h1;
      port2AmberIndicatorOe <= 1'h1;
      port2AmberIndicatorOut <= hscp_led(amberReq[2], ~cap.ind2);
      port1AmberIndicatorOe <= 1'h1;
      port1AmberIndicatorOut <= hscp_led(amberReq[1], ~cap.ind1);
    end else begin
      port4AmberIndicatorOe <= cfgIndicatorEnable;
      port2AmberIndicatorOe <= cfgIndicatorEnable;
      port1AmberIndicatorOe <= cfgIndicatorEnable;
      port4AmberIndicatorOut <= ~amberReq[4];
      port2AmberIndicatorOut <= ~amberReq[2];
      port1AmberIndicatorOut <= ~amberReq[1];
    end
  end

  // Port 3 carries no strap and is always driven
  always_ff @(posedge clk) begin
    port3AmberIndicatorOe <= 1'h1;
    if (rst) begin
      port3AmberIndicatorOut <= 1'h1;
    end else begin
      port3AmberIndicatorOut <= ~amberReq[3];
    end
  end

  // ****************************************
  // Downstream port power
  // ****************************************
  logic [7:1] effPowerReq;
  logic [7:1] supplyReg;

  // Ganged mode switches every port together
  assign effPowerReq = cap.ind1 && capStrapMode || !capStrapMode && cfgGanged ?
                       {NumPorts{|portPowerReq}} : portPowerReq;

  always_ff @(posedge clk) begin
    if (rst) begin
      supplyReg <= hscp_level(PortsOff, pinSync.supplyLevel);
    end else begin
      supplyReg <= hscp_level(effPowerReq, cap.supplyLevel);
    end
  end

  // Reset path bypasses the register so no port is ever powered in reset
  assign downstreamSupplyEnable = rst ? hscp_level(PortsOff, pinSync.supplyLevel)
                                      : supplyReg;

  // ****************************************
  // Over-current sensing
  // ****************************************
  logic [7:1] overRaw;

  // Undriven inputs idle high, so only a low level reports a fault
  assign overRaw = ~pinSync.overN;

  always_ff @(posedge clk) begin
    if (rst) begin
      overcurrent <= OverAtReset;
    end else if (next_activeCfg.ganged) begin
      overcurrent <= {NumPorts{|overRaw}};
    end else begin
      overcurrent <= overRaw;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  // Marks the synchroniser as filled, so checks skip its unknown power-up levels
  logic [1:0] syncFill;

  always_ff @(posedge clk) begin
    syncFill <= {syncFill[0], 1'h1};
  end

  chk_select_decode: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) |=> activeCfg.useStrap == ($past(pinSync.cfgSelHi, 2) && !$past(pinSync.cfgSelLo, 2)))
    else $error("configuration method decode wrong");

  chk_indicator_sample: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) ##1 activeCfg.useStrap |-> activeCfg.indicatorEnable == $past(pinSync.ind4, 2))
    else $error("indicator enable strap not taken at release");

  chk_indicator_off: assert property (@(posedge clk) disable iff (rst)
    strapsValid && activeCfg.useStrap && !activeCfg.indicatorEnable |->
      port4AmberIndicatorOe && port4AmberIndicatorOut)
    else $error("disabled indicator not held inactive");

  chk_loaded_leds_low: assert property (@(posedge clk) disable iff (rst)
    !capStrapMode && cfgIndicatorEnable |=>
      port2AmberIndicatorOe && port2AmberIndicatorOut == !$past(amberReq[2]))
    else $error("loaded indicator not active low");

  chk_port3_low: assert property (@(posedge clk) disable iff (rst)
    !rst |=> port3AmberIndicatorOe && port3AmberIndicatorOut == !$past(amberReq[3]))
    else $error("port 3 indicator not active low");

  chk_translator_sample: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) ##1 activeCfg.useStrap |-> activeCfg.multiTranslators == $past(pinSync.ind2, 2))
    else $error("translator strap not taken at release");

  chk_port2_level: assert property (@(posedge clk) disable iff (rst)
    capStrapMode |=> port2AmberIndicatorOut == ($past(cap.ind2) ? !$past(amberReq[2])
                                                                 : $past(amberReq[2])))
    else $error("port 2 indicator level wrong");

  chk_gang_sample: assert property (@(posedge clk) disable iff (rst)
    $fell(rst) ##1 activeCfg.useStrap |-> activeCfg.ganged == $past(pinSync.ind1, 2))
    else $error("gang strap not taken at release");

  chk_port1_level: assert property (@(posedge clk) disable iff (rst)
    capStrapMode |=> port1AmberIndicatorOut == ($past(cap.ind1) ? !$past(amberReq[1])
                                                                 : $past(amberReq[1])))
    else $error("port 1 indicator level wrong");

  chk_reset_power_off: assert property (@(posedge clk)
    syncFill[1] && rst |-> downstreamSupplyEnable == {NumPorts{!pinSync.supplyLevel}})
    else $error("port powered during reset");

  chk_polarity_latched: assert property (@(posedge clk) disable iff (rst)
    strapsValid |=> downstreamSupplyEnable == hscp_level(activeCfg.ganged ?
      {NumPorts{|$past(portPowerReq)}} : $past(portPowerReq), activeCfg.supplyLevel))
    else $error("supply enable ignores latched polarity");

  chk_straps_hold: assert property (@(posedge clk) disable iff (rst)
    !$past(rst) |-> $stable(cap) && ($past(rst, 2) || $stable(activeCfg.supplyLevel)))
    else $error("captured strap changed after release");

  cov_strap_release: cover property (@(posedge clk)
    $fell(rst) ##1 activeCfg.useStrap);

  cov_loaded_release: cover property (@(posedge clk)
    $fell(rst) ##1 !activeCfg.useStrap && cfgIndicatorEnable);

  cov_ganged_fault: cover property (@(posedge clk) disable iff (rst)
    activeCfg.ganged && overcurrent == {NumPorts{1'h1}});

  cov_active_low_power: cover property (@(posedge clk) disable iff (rst)
    strapsValid && !cap.supplyLevel && portPowerReq != PortsOff);

endmodule

// ==== hscp_board.sv ====
// Board side model: strap resistors, indicator pins and current monitors
`timescale 1ns/1ps
module hscp_board (
  // Strap resistor levels
  input wire logic strapInd4,
  input wire logic strapInd2,
  input wire logic strapInd1,
  // Indicator drive from the hub
  input wire logic out4,
  input wire logic oe4,
  input wire logic out2,
  input wire logic oe2,
  input wire logic out1,
  input wire logic oe1,
  // Current monitor faults, high means fault
  input wire logic [7:1] fault,
  // Resolved pin levels
  output logic pin4,
  output logic pin2,
  output logic pin1,
  output logic [7:1] overN
);
  // Released pins settle to the strap resistor level
  assign pin4 = oe4 ? out4 : strapInd4;
  assign pin2 = oe2 ? out2 : strapInd2;
  assign pin1 = oe1 ? out1 : strapInd1;
  // Monitor pulls low on a fault, internal pull-up holds it high otherwise
  assign overN = ~fault;
endmodule

// ==== tb.sv ====
// Self-checking testbench for the hub strap capture block
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin nMismatch++; \
  $display("[ERR] t=%0t got %h exp %h", $time, a, b); end end
module tb;
  import hscp_pkg::*;
  typedef struct packed {
    logic [7:0] ind;
    logic [7:1] sup;
    logic [7:1] oc;
    hscp_cfg_s cfg;
    logic vld;
  } hscp_exp_s;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic selHi = 1'h0;
  logic selLo = 1'h0;
  logic [2:0] cfgIn = 3'h0;
  logic [4:1] amberReq = 4'h0;
  logic [7:1] powerReq = 7'h00;
  logic [7:1] fault = 7'h00;
  logic [3:0] strap = 4'h0;
  logic [3:0] capS = 4'h0;
  logic [7:1] overN, supply, overcurrent;
  logic pin4, pin2, pin1, p4o, p4e, p3o, p3e, p2o, p2e, p1o, p1e, vld;
  hscp_cfg_s acfg;
  hscp_exp_s expQ[$];
  event sampleEv;
  int nMismatch = 0;
  int checked = 0;
  int seed;
  logic [31:0] rnd;
  always #12.5 clk = ~clk;
  hscp_board u_board (.strapInd4(strap[3]), .strapInd2(strap[2]), .strapInd1(strap[1]),
    .out4(p4o), .oe4(p4e), .out2(p2o), .oe2(p2e), .out1(p1o), .oe1(p1e), .fault(fault),
    .pin4(pin4), .pin2(pin2), .pin1(pin1), .overN(overN));
  hscp_strap_capture u_dut (.clk(clk), .rst(rst), .configMethodSelectHi(selHi),
    .configMethodSelectLo(selLo), .cfgIndicatorEnable(cfgIn[2]),
    .cfgMultiTranslators(cfgIn[1]), .cfgGanged(cfgIn[0]), .amberReq(amberReq),
    .port4AmberIndicatorIn(pin4), .port4AmberIndicatorOut(p4o), .port4AmberIndicatorOe(p4e),
    .port3AmberIndicatorOut(p3o), .port3AmberIndicatorOe(p3e),
    .port2AmberIndicatorIn(pin2), .port2AmberIndicatorOut(p2o), .port2AmberIndicatorOe(p2e),
    .port1AmberIndicatorIn(pin1), .port1AmberIndicatorOut(p1o), .port1AmberIndicatorOe(p1e),
    .supplySwitchLevelStrap(strap[0]), .portPowerReq(powerReq),
    .downstreamSupplyEnable(supply), .overcurrentSenseN(overN), .overcurrent(overcurrent),
    .activeCfg(acfg), .strapsValid(vld));
  // Expected outputs from straps {enable, translators, gang, polarity}
  function automatic hscp_exp_s expect_of(input logic r, input logic [3:0] s,
      input logic [1:0] sel, input logic [2:0] c, input logic [4:1] a,
      input logic [7:1] p, input logic [7:1] f);
    hscp_exp_s e;
    logic useS, en, m, g;
    logic [7:1] pg;
    useS = (sel == CfgSelStrap);
    en = useS ? s[3] : c[2];
    m = useS ? s[2] : c[1];
    g = useS ? s[1] : c[0];
    pg = g ? {7{|p}} : p;
    e.cfg = {useS, en, m, g, s[0]};
    e.sup = r ? {7{~s[0]}} : (s[0] ? pg : ~pg);
    e.oc = g ? {7{|f}} : f;
    e.vld = ~r;
    if (useS) begin
      e.ind = {en ? ~a[4] : 1'h1, 1'h1, ~a[3], 1'h1, m ? ~a[2] : a[2], 1'h1,
        g ? ~a[1] : a[1], 1'h1};
    end else begin
      e.ind = {~a[4], en, ~a[3], 1'h1, ~a[2], en, ~a[1], en};
    end
    return e;
  endfunction
  task automatic check_now(input logic r);
    @(negedge clk);
    expQ.push_back(expect_of(r, r ? strap : capS, {selHi, selLo}, cfgIn, amberReq,
      powerReq, fault));
    -> sampleEv;
  endtask
  // ****************************************
  // Output monitor
  // ****************************************
  always @(sampleEv) begin
    hscp_exp_s e;
    e = expQ.pop_front();
    `CHK(supply, e.sup)
    `CHK(vld, e.vld)
    if (e.vld === 1'h1) begin
      `CHK({p4o, p4e, p3o, p3e, p2o, p2e, p1o, p1e}, e.ind)
      `CHK(overcurrent, e.oc)
      `CHK(acfg, e.cfg)
    end
  end
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d mismatched", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    seed = 91;
    for (int i = 0; i < 16; i++) begin
      rnd = $random(seed);
      @(posedge clk);
      rst <= 1'h1;
      strap <= rnd[3:0];
      {selHi, selLo} <= i[1:0];
      cfgIn <= rnd[6:4];
      amberReq <= 4'h0;
      powerReq <= rnd[13:7];
      fault <= 7'h00;
      repeat (5) @(posedge clk);
      check_now(1'h1);
      repeat (2) @(posedge clk);
      capS = strap;
      rst <= 1'h0;
      repeat (4) begin
        @(posedge clk);
        rnd = $random(seed);
        amberReq <= rnd[3:0];
        powerReq <= rnd[10:4];
        fault <= rnd[17:11] & {7{rnd[18]}};
        // Straps move after release and must be ignored
        strap <= rnd[22:19];
        repeat (4) @(posedge clk);
        check_now(1'h0);
      end
      $display("Test %0d ended, select %0d", i, i[1:0]);
    end
    give_verdict();
  end
  initial begin
    #(3000 * 25);
    nMismatch++;
    $display("Watchdog expired");
    give_verdict();
  end
endmodule
